// >>> hdl/sciec_pkg.sv
// Purpose: constants for the interrupt-enable mask of the clock and
//          supply controller (offsets, field positions, reset values)
// Assumes: one 50 MHz clock mclk, synchronous active-low reset
// Notes:   offsets, reset values, size codes and field positions are named here once
//
// Overview of operation
// - byte, halfword and word accesses all accepted
// - each byte lane and half written alone
// - guard protection blocks enable register writes
// - source flags synchronised before taking effect
// - writing ones to clear register disables sources
// - one enable set seen through both registers
// - unused bits always read back as zero
// - writing zero leaves an enable unchanged
// - enabled source with flag set raises request
// - phase loop enables at bits 17..15
// - brownout enables at bits 11..9
// - freq loop enables at bits 8..6
// - freq loop bounds bit5, ready bit4
// - fast rc bit3, slow rc bit2
// - slow crystal bit1, crystal bit0
package sciec_pkg;

   // bus geometry
   localparam int ADDR_W = 8;   // byte address width
   localparam int DATA_W = 32;  // data width
   localparam int FLAG_W = 18;  // source flag inputs, bits 17..0

   // register offsets (byte addresses)
   localparam logic [7:0] OFF_ENABLE_CLEAR = 8'h00;
   localparam logic [7:0] OFF_ENABLE_SET   = 8'h04;
   localparam logic [7:0] OFF_FLAG_STATUS  = 8'h08;

   // reset values
   localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
   localparam logic [31:0] RST_STATUS = 32'h0000_0000;
   localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

   // access size codes on the bus
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // enable field positions
   localparam int POS_PHASE_LOOP_TIMEOUT   = 17;
   localparam int POS_PHASE_LOOP_LOCK_FALL = 16;
   localparam int POS_PHASE_LOOP_LOCK_RISE = 15;
   localparam int POS_BROWNOUT_SYNC_READY  = 11;
   localparam int POS_BROWNOUT_DETECT      = 10;
   localparam int POS_BROWNOUT_READY       = 9;
   localparam int POS_FREQ_LOOP_REF_STOP   = 8;
   localparam int POS_FREQ_LOOP_COARSE     = 7;
   localparam int POS_FREQ_LOOP_FINE       = 6;
   localparam int POS_FREQ_LOOP_OOB        = 5;
   localparam int POS_FREQ_LOOP_READY      = 4;
   localparam int POS_FAST_RC_OSC_READY    = 3;
   localparam int POS_SLOW_RC_OSC_READY    = 2;
   localparam int POS_SLOW_CRYSTAL_READY   = 1;
   localparam int POS_CRYSTAL_OSC_READY    = 0;

endpackage : sciec_pkg

// >>> hdl/sciec_sync.sv
// Purpose: two-flop synchroniser for a vector of level signals
// Assumes: each bit is a slow level, no bus coherency needed
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps

module sciec_sync #(
   parameter int WIDTH = 1   // number of bits carried
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] stage1_q;  // metastable catch stage
   logic [WIDTH-1:0] stage2_q;  // settled stage

   // two flops, cleared by reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         stage1_q <= '0;
         stage2_q <= '0;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;

endmodule // sciec_sync

// >>> hdl/sciec_lanes.sv
// Purpose: byte-lane selection from access size and low address bits
// Assumes: byte lanes sit in place on the 32-bit data bus
// Notes:   a misaligned access yields no lanes; a misaligned write is ignored, a read is not
`timescale 1ns/1ps

module sciec_lanes (
   input  wire logic [1:0] addrLow,
   input  wire logic [1:0] accSize,
   output logic      [3:0] laneMask,
   output logic            aligned
);

   wire logic isByte;   // byte access
   wire logic isHalf;   // halfword access
   wire logic isWord;   // word access
   wire logic [3:0] byteLanes;  // one lane of four
   wire logic [3:0] halfLanes;  // low or high half

   assign isByte = (accSize == sciec_pkg::SIZE_BYTE);
   assign isHalf = (accSize == sciec_pkg::SIZE_HALF);
   assign isWord = (accSize == sciec_pkg::SIZE_WORD);

   // one-hot lane for bytes, pair for halves
   assign byteLanes = 4'h1 << addrLow;
   assign halfLanes = addrLow[1] ? 4'hc : 4'h3;

   // halves need even address, words need aligned address
   assign aligned = isByte
                  | (isHalf & ~addrLow[0])
                  | (isWord & (addrLow == 2'h0));

   assign laneMask = !aligned ? 4'h0
                   : isByte ? byteLanes
                   : isHalf ? halfLanes
                   : 4'hf;

endmodule // sciec_lanes

// >>> hdl/sciec_top.sv
// Purpose: interrupt-enable mask with clear and set views, sticky
//          source flag status and one combined interrupt request
// Assumes: register port on mclk, source flags from other domains,
//          access guard level from logic on mclk
// Notes:   read data stand one cycle after the read strobe only
`timescale 1ns/1ps

module sciec_top (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  busAddr,
   input  wire logic [1:0]  busSize,
   input  wire logic [31:0] busWrData,
   input  wire logic        busWrStrobe,
   input  wire logic        busRdStrobe,
   output logic      [31:0] busRdData,
   input  wire logic        accessGuardProtect,
   input  wire logic [17:0] srcFlag,
   output logic             irq
);

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [31:0] enable_q;     // shared enable bits
   logic [31:0] enable_d;     // next enable bits
   logic [31:0] status_q;     // sticky source flags
   logic [31:0] status_d;     // next sticky flags
   logic [31:0] rdData_q;     // registered read data
   logic [31:0] rdData_d;     // next read data
   logic        irq_q;        // registered request
   logic        irq_d;        // next request

   // ------------------------------------------------------------
   // decode wires
   // ------------------------------------------------------------
   wire logic [7:0]  wordAddr;   // address with lane bits dropped
   wire logic [3:0]  laneMask;   // lanes of this access
   wire logic        aligned;    // access shape is legal
   wire logic [31:0] laneBits;   // lanes widened to bits
   wire logic [31:0] implBits;   // implemented enable positions
   wire logic [31:0] wrBits;     // written ones in live lanes
   wire logic        hitClear;   // clear view addressed
   wire logic        hitSet;     // set view addressed
   wire logic        hitStatus;  // flag status addressed
   wire logic        enWrAllow;  // enable write not blocked
   wire logic        clrWrite;   // effective clear write
   wire logic        setWrite;   // effective set write
   wire logic        stsWrite;   // effective status write
   wire logic [17:0] flagSync;   // synchronised source flags
   wire logic [31:0] flagBits;   // flags at register positions
   wire logic [31:0] rdSelect;   // read data selected now

   // implemented positions; everything else is reserved
   assign implBits =
        (32'h1 << sciec_pkg::POS_PHASE_LOOP_TIMEOUT)
      | (32'h1 << sciec_pkg::POS_PHASE_LOOP_LOCK_FALL)
      | (32'h1 << sciec_pkg::POS_PHASE_LOOP_LOCK_RISE)
      | (32'h1 << sciec_pkg::POS_BROWNOUT_SYNC_READY)
      | (32'h1 << sciec_pkg::POS_BROWNOUT_DETECT)
      | (32'h1 << sciec_pkg::POS_BROWNOUT_READY)
      | (32'h1 << sciec_pkg::POS_FREQ_LOOP_REF_STOP)
      | (32'h1 << sciec_pkg::POS_FREQ_LOOP_COARSE)
      | (32'h1 << sciec_pkg::POS_FREQ_LOOP_FINE)
      | (32'h1 << sciec_pkg::POS_FREQ_LOOP_OOB)
      | (32'h1 << sciec_pkg::POS_FREQ_LOOP_READY)
      | (32'h1 << sciec_pkg::POS_FAST_RC_OSC_READY)
      | (32'h1 << sciec_pkg::POS_SLOW_RC_OSC_READY)
      | (32'h1 << sciec_pkg::POS_SLOW_CRYSTAL_READY)
      | (32'h1 << sciec_pkg::POS_CRYSTAL_OSC_READY);

   // byte lanes from size and low address
   sciec_lanes u_lanes (
      .addrLow  (busAddr[1:0]),
      .accSize  (busSize),
      .laneMask (laneMask),
      .aligned  (aligned)
   );

   // widen lanes so a byte or half touches only its own bits
   assign laneBits = {{8{laneMask[3]}}, {8{laneMask[2]}},
                      {8{laneMask[1]}}, {8{laneMask[0]}}};

   // only ones in live, implemented lanes act
   assign wrBits = busWrData & laneBits & implBits;

   // word decode ignores the lane bits of the address
   assign wordAddr  = {busAddr[7:2], 2'h0};
   assign hitClear  = (wordAddr == sciec_pkg::OFF_ENABLE_CLEAR);
   assign hitSet    = (wordAddr == sciec_pkg::OFF_ENABLE_SET);
   assign hitStatus = (wordAddr == sciec_pkg::OFF_FLAG_STATUS);

   // guard protection blocks both enable views
   assign enWrAllow = ~accessGuardProtect;

   assign clrWrite = busWrStrobe & hitClear & aligned & enWrAllow;
   assign setWrite = busWrStrobe & hitSet & aligned & enWrAllow;
   assign stsWrite = busWrStrobe & hitStatus & aligned;

   // ------------------------------------------------------------
   // source flags cross into mclk before they can set status
   // ------------------------------------------------------------
   sciec_sync #(
      .WIDTH (sciec_pkg::FLAG_W)
   ) u_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .asyncIn (srcFlag),
      .syncOut (flagSync)
   );

   // flags sit at the same positions as their enables
   assign flagBits = {14'h0, flagSync} & implBits;

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------

   // one set of enable bits behind two views
   always_comb begin
      enable_d = enable_q;
      if (clrWrite) begin
         // ones clear, zeros keep
         enable_d = enable_q & ~wrBits;
      end else if (setWrite) begin
         // ones set, zeros keep
         enable_d = enable_q | wrBits;
      end
   end

   // sticky flags: a new flag wins over a one-to-clear
   always_comb begin
      status_d = status_q;
      if (stsWrite) begin
         status_d = status_q & ~wrBits;
      end
      status_d = status_d | flagBits;
   end

   // request: any flag whose enable is set
   assign irq_d = |(status_q & enable_q);

   // read mux; reserved bits are zero in every view
   assign rdSelect = (hitClear | hitSet) ? (enable_q & implBits)
                   : hitStatus ? (status_q & implBits)
                   : sciec_pkg::RST_RDATA;

   // data valid only in the cycle after the strobe
   assign rdData_d = busRdStrobe ? rdSelect
                                 : sciec_pkg::RST_RDATA;

   // ------------------------------------------------------------
   // state registers
   // ------------------------------------------------------------

   // enable bits
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         enable_q <= sciec_pkg::RST_ENABLE;
      end else begin
         enable_q <= enable_d;
      end
   end

   // sticky flags
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         status_q <= sciec_pkg::RST_STATUS;
      end else begin
         status_q <= status_d;
      end
   end

   // read data and request
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdData_q <= sciec_pkg::RST_RDATA;
         irq_q    <= 1'b0;
      end else begin
         rdData_q <= rdData_d;
         irq_q    <= irq_d;
      end
   end

   assign busRdData = rdData_q;
   assign irq       = irq_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------

   // word clear write drops every written implemented bit
   clear_word_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && !accessGuardProtect
       && busAddr == sciec_pkg::OFF_ENABLE_CLEAR
       && busSize == sciec_pkg::SIZE_WORD)
      |=> ((enable_q & $past(busWrData)) == 32'h0))
      else $error("clear write left an enable set");

   // protected writes leave the enables untouched
   guard_block_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && accessGuardProtect
       && (hitClear || hitSet))
      |=> $stable(enable_q))
      else $error("protected write changed enables");

   // zeros written to clear keep their bits
   zero_keep_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && hitClear)
      |=> ((enable_q & ~$past(busWrData))
           == ($past(enable_q) & ~$past(busWrData))))
      else $error("zero written changed an enable");

   // both views read the same enable bits
   shared_view_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busRdStrobe && (hitClear || hitSet) && !busWrStrobe)
      |=> (busRdData == $past(enable_q)))
      else $error("enable view mismatch");

   // set then read back through the clear view
   set_to_clear_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && !accessGuardProtect
       && busAddr == sciec_pkg::OFF_ENABLE_SET
       && busSize == sciec_pkg::SIZE_WORD && busWrData[0])
      ##1 !busWrStrobe
      ##1 (busRdStrobe && busAddr == sciec_pkg::OFF_ENABLE_CLEAR)
      |=> busRdData[0])
      else $error("set not visible in clear view");

   // reserved ranges never read back as one
   reserved_zero_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busRdData[31:18] == 14'h0) && (busRdData[14:12] == 3'h0))
      else $error("reserved bits read as one");

   // a byte write to lane 2 clears bit 17 only
   byte_lane_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && !accessGuardProtect
       && busAddr == 8'h02 && busSize == sciec_pkg::SIZE_BYTE
       && busWrData[17])
      |=> (!enable_q[17]
           && enable_q[16:0] == $past(enable_q[16:0])))
      else $error("byte lane write misplaced");

   // a halfword to the low half leaves the high half
   half_lane_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && hitClear && busAddr[1:0] == 2'h0
       && busSize == sciec_pkg::SIZE_HALF)
      |=> (enable_q[31:16] == $past(enable_q[31:16])))
      else $error("halfword write hit high half");

   // held flag with enable reaches the request in four cycles
   flag_to_irq_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (srcFlag[sciec_pkg::POS_BROWNOUT_DETECT]
       && enable_q[sciec_pkg::POS_BROWNOUT_DETECT]) [*4] |=> irq)
      else $error("enabled flag raised no request");

   // no enables, no request
   masked_quiet_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (enable_q == 32'h0) |=> !irq)
      else $error("request with all sources disabled");

   // flag arriving during its clear stays set
   set_wins_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (stsWrite && busWrData[sciec_pkg::POS_BROWNOUT_DETECT]
       && flagSync[sciec_pkg::POS_BROWNOUT_DETECT])
      |=> status_q[sciec_pkg::POS_BROWNOUT_DETECT])
      else $error("flag lost to a clear");

   // read data stand one cycle only
   rd_single_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !busRdStrobe |=> (busRdData == 32'h0))
      else $error("read data outside read cycle");

   // a word set write raises every written implemented bit
   set_word_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (setWrite && busSize == sciec_pkg::SIZE_WORD)
      |=> ((enable_q & $past(busWrData) & implBits)
           == ($past(busWrData) & implBits)))
      else $error("set write left an enable clear");

   // enables move only on an allowed write to a view
   enable_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !(clrWrite || setWrite) |=> $stable(enable_q))
      else $error("enables changed without a write");

   // a clear write never raises an enable
   clear_falls_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      clrWrite |=> ((enable_q & ~$past(enable_q)) == 32'h0))
      else $error("clear write raised an enable");

   // a high half write leaves the low half
   half_high_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && hitClear && busAddr[1:0] == 2'h2
       && busSize == sciec_pkg::SIZE_HALF)
      |=> (enable_q[15:0] == $past(enable_q[15:0])))
      else $error("halfword write hit low half");

   // a byte to lane 1 leaves lanes 0, 2 and 3
   byte_mid_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busWrStrobe && hitClear && busAddr[1:0] == 2'h1
       && busSize == sciec_pkg::SIZE_BYTE)
      |=> (enable_q[31:16] == $past(enable_q[31:16])
           && enable_q[7:0] == $past(enable_q[7:0])))
      else $error("byte write hit another lane");

   // status bits hold until written with a one
   status_hold_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      !stsWrite |=> ((status_q & $past(status_q)) == $past(status_q)))
      else $error("status bit lost without a clear");

   // a synchronised flag always lands in the status
   flag_status_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (|flagBits) |=> ((status_q & $past(flagBits)) == $past(flagBits)))
      else $error("synchronised flag not in status");

   // a flag needs both flops before it is seen
   sync_rise_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      $rose(flagSync[sciec_pkg::POS_BROWNOUT_DETECT])
      |-> $past(srcFlag[sciec_pkg::POS_BROWNOUT_DETECT], 2))
      else $error("flag crossed in under two cycles");

   // any unmasked status bit drives the request next cycle
   irq_or_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (|(status_q & enable_q)) |=> irq)
      else $error("unmasked status raised no request");

   // a status read returns the sticky flags
   status_read_a: assert property (
      @(posedge mclk) disable iff (!rst_n)
      (busRdStrobe && hitStatus && !busWrStrobe)
      |=> (busRdData == $past(status_q)))
      else $error("status read mismatch");

endmodule // sciec_top

// >>> dv/tb_top.sv
// Purpose: self-checking bench for the interrupt-enable mask block
// Assumes: bus tasks drive on rising edges, read data one cycle later
// Notes:   expected enables are kept in a bench-side mirror enExp
`timescale 1ns/1ps

module tb_top;
   localparam logic [31:0] ALL_EN = 32'h0003_8fff; // implemented bits
   localparam logic [1:0]  WORD   = sciec_pkg::SIZE_WORD;
   localparam logic [1:0]  HALF   = sciec_pkg::SIZE_HALF;
   localparam logic [1:0]  BYTE   = sciec_pkg::SIZE_BYTE;

   logic        mclk;               // 50 MHz clock
   logic        rst_n;              // synchronous reset, active low
   logic [7:0]  busAddr;            // byte address
   logic [1:0]  busSize;            // access size code
   logic [31:0] busWrData;          // write data, lanes in place
   logic        busWrStrobe;        // one-cycle write strobe
   logic        busRdStrobe;        // one-cycle read strobe
   logic [31:0] busRdData;          // read data, one cycle after strobe
   logic        accessGuardProtect; // write protection level
   logic [17:0] srcFlag;            // source event levels
   logic        irq;                // combined interrupt request
   logic [31:0] enExp;              // mirror of the enable bits
   int          errCount;           // mismatches seen
   int          checks;             // comparisons made
   int          n;                  // wait counter

   sciec_top sciec_top_i (
      .mclk               (mclk),
      .rst_n              (rst_n),
      .busAddr            (busAddr),
      .busSize            (busSize),
      .busWrData          (busWrData),
      .busWrStrobe        (busWrStrobe),
      .busRdStrobe        (busRdStrobe),
      .busRdData          (busRdData),
      .accessGuardProtect (accessGuardProtect),
      .srcFlag            (srcFlag),
      .irq                (irq)
   );

   // free-running clock, 20 ns period
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // compare one value and count it
   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errCount++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   // one-cycle write strobe beside address, size and data
   task automatic wr(input logic [7:0] a, input logic [1:0] s,
                     input logic [31:0] d);
      @(posedge mclk);
      busAddr     <= a;
      busSize     <= s;
      busWrData   <= d;
      busWrStrobe <= 1'b1;
      @(posedge mclk);
      busWrStrobe <= 1'b0;
   endtask

   // one-cycle read strobe; data looked at in the following cycle only
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input string name);
      @(posedge mclk);
      busAddr     <= a;
      busSize     <= WORD;
      busRdStrobe <= 1'b1;
      @(posedge mclk);
      busRdStrobe <= 1'b0;
      @(negedge mclk);
      chk(name, exp, busRdData);
   endtask

   // wait a bounded number of cycles for irq to reach a level
   task automatic waitIrq(input logic lvl);
      n = 0;
      // look only where irq has settled, never at the edge
      @(negedge mclk);
      while (irq !== lvl && n < 8) begin
         @(negedge mclk);
         n++;
      end
      chk("irq", {31'h0, lvl}, {31'h0, irq});
   endtask

   // counts, verdict and end of run
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", checks, errCount);
      if (errCount == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // watchdog: the tests need well under 2000 cycles
   initial begin
      #(20 * 5000);
      errCount++;
      $display("unexpected timeout: expected done seen hung");
      print_verdict();
   end

   // main sequence
   initial begin
      rst_n = 1'b0;
      busAddr = 8'h00;
      busSize = WORD;
      busWrData = 32'h0000_0000;
      busWrStrobe = 1'b0;
      busRdStrobe = 1'b0;
      accessGuardProtect = 1'b0;
      srcFlag = 18'h00000;
      errCount = 0;
      checks = 0;
      repeat (9) @(posedge mclk);
      @(negedge mclk);
      chk("irq in reset", 32'h0, {31'h0, irq});
      chk("rdata in reset", 32'h0, busRdData);
      // release on the tenth rising edge
      @(posedge mclk);
      rst_n <= 1'b1;
      // reset values of both views and the status
      rd(8'h00, 32'h0, "clear view reset");
      rd(8'h04, 32'h0, "set view reset");
      rd(8'h08, 32'h0, "status reset");
      rd(8'h10, 32'h0, "unmapped read");
      $display("test reset done");

      // all implemented ones through set view, reserved written zero
      wr(8'h04, WORD, ALL_EN);
      enExp = ALL_EN;
      rd(8'h00, enExp, "clear view after set");
      wr(8'h00, WORD, 32'h0000_0000);
      rd(8'h00, enExp, "clear view after zero");
      // one bit at a time through the clear view
      for (int i = 0; i < 18; i++) begin
         if (i < 12 || i > 14) begin
            wr(8'h00, WORD, 32'h1 << i);
            enExp[i] = 1'b0;
            rd(8'h04, enExp, "set view after clear");
         end
      end
      $display("test clear bits done");

      // byte and halfword lanes of the clear view
      wr(8'h04, WORD, ALL_EN);
      enExp = ALL_EN;
      wr(8'h02, BYTE, 32'h0002_00ff);
      enExp[17] = 1'b0;
      rd(8'h00, enExp, "byte lane 2");
      wr(8'h01, BYTE, 32'h0000_08ff);
      enExp[11] = 1'b0;
      rd(8'h00, enExp, "byte lane 1");
      wr(8'h00, HALF, 32'h0001_0001);
      enExp[0] = 1'b0;
      rd(8'h00, enExp, "low half");
      wr(8'h02, HALF, 32'h0001_0000);
      enExp[16] = 1'b0;
      rd(8'h00, enExp, "high half");
      $display("test lanes done");

      // guarded writes are ignored, then take effect when released
      @(posedge mclk);
      accessGuardProtect <= 1'b1;
      wr(8'h00, WORD, ALL_EN);
      rd(8'h00, enExp, "clear while guarded");
      @(posedge mclk);
      accessGuardProtect <= 1'b0;
      wr(8'h00, WORD, ALL_EN);
      enExp = 32'h0;
      rd(8'h00, enExp, "clear after guard");
      $display("test guard done");

      // source flags: synchronised, sticky, masked and unmasked
      wr(8'h04, WORD, 32'h0000_0400);
      @(posedge mclk);
      srcFlag <= 18'h00408;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk("irq before sync", 32'h0, {31'h0, irq});
      waitIrq(1'b1);
      wr(8'h00, WORD, 32'h0000_0400);
      waitIrq(1'b0);
      @(posedge mclk);
      srcFlag <= 18'h00000;
      rd(8'h08, 32'h0000_0408, "sticky status");
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk("irq masked source", 32'h0, {31'h0, irq});
      wr(8'h04, WORD, 32'h0000_0400);
      waitIrq(1'b1);
      wr(8'h08, WORD, 32'h0000_0408);
      waitIrq(1'b0);
      rd(8'h08, 32'h0, "status cleared");
      rd(8'h00, 32'h0000_0400, "enable kept");
      $display("test interrupt done");

      // a clear that meets a standing source leaves its flag set
      @(posedge mclk);
      srcFlag <= 18'h00400;
      repeat (4) @(posedge mclk);
      wr(8'h08, WORD, 32'h0000_0400);
      rd(8'h08, 32'h0000_0400, "flag over clear");
      waitIrq(1'b1);
      @(posedge mclk);
      srcFlag <= 18'h00000;
      $display("test set wins done");
      print_verdict();
   end
endmodule // tb_top
